// >>> hdl/fifo_rt_pkg.sv
/*
  Shared constants and types for the retransmit-capable FIFO with
  programmable flags: depths, thresholds, offset defaults, loader step
  counts and retransmit setup timing.
  Assumes a single 125 MHz system clock; every user of these names writes
  fifo_rt_pkg::name.
*/
package fifo_rt_pkg;
  // data path geometry
  localparam int WORD_W = 18;
  localparam int ADDR_W = 17;
  localparam int MEM_DEPTH = 131072;
  localparam int FILL_W = 18;
  localparam int OFFSET_W = 17;
  localparam int STEP_W = 5;
  // usable depths, passthrough mode holds one word more
  localparam logic [17:0] DEPTH_STANDARD = 18'h20000;
  localparam logic [17:0] DEPTH_PASSTHROUGH = 18'h20001;
  // half-full goes low once the fill passes these
  localparam logic [17:0] HALF_STANDARD = 18'h10000;
  localparam logic [17:0] HALF_PASSTHROUGH = 18'h10001;
  // serial offset bits per offset
  localparam logic [4:0] SERIAL_BITS_NARROW = 5'h11;
  localparam logic [4:0] SERIAL_BITS_WIDE = 5'h10;
  // last parallel step index for the pair of offsets
  localparam logic [1:0] PAR_LAST_WIDE = 2'h1;
  localparam logic [1:0] PAR_LAST_NARROW = 2'h3;
  localparam int NARROW_W = 9;
  // offsets restored by master reset
  localparam logic [16:0] DEFAULT_EMPTY_OFFSET = 17'h003FF;
  localparam logic [16:0] DEFAULT_FULL_OFFSET = 17'h003FF;
  // normal-latency retransmit setup time
  localparam int CLK_PERIOD_NS = 8;
  localparam int RT_SETUP_TIME_NS = 32;
  localparam int RT_SETUP_CYCLES_INT = (RT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RT_SETUP_CYCLES = RT_SETUP_CYCLES_INT[3:0];
  // configuration reset values
  localparam logic CFG_NORMAL_RT_RESET = 1'b1;
  localparam logic CFG_SYNC_FLAGS_RESET = 1'b1;

  typedef enum logic [0:0] {RT_IDLE, RT_SETUP} rt_state_type;
endpackage

// >>> hdl/two_entry_buffer.sv
/*
  Two-entry buffer with valid/ready on both sides and a flush.
  Entry 0 is always the head, so the output data comes straight from a
  flip-flop. Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module two_entry_buffer (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_i, // async reset, high
  input wire logic flush_i, // drop contents, push still taken
  input wire logic in_valid_i, // word offered
  input wire logic [17:0] in_data_i, // word in
  output logic in_ready_o, // room for a word
  output logic out_valid_o, // head word valid
  output logic [17:0] out_data_o, // head word
  input wire logic out_ready_i // head taken
);
  logic [17:0] entry1;
  logic [1:0] level;
  logic push;
  logic pop;

  // handshakes; a full buffer still takes a word when the head leaves
  assign in_ready_o = (level != 2'h2) || out_ready_i;
  assign out_valid_o = (level != 2'h0);
  assign push = in_valid_i && (flush_i || in_ready_o);
  assign pop = out_valid_o && out_ready_i && !flush_i;

  // occupancy
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      level <= 2'h0;
    end else if (flush_i) begin
      level <= push ? 2'h1 : 2'h0;
    end else if (push && !pop) begin
      level <= level + 2'h1;
    end else if (pop && !push) begin
      level <= level - 2'h1;
    end
  end

  // storage; shift on pop keeps the head in entry 0
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      out_data_o <= 18'h00000;
      entry1 <= 18'h00000;
    end else if (flush_i) begin
      if (push) begin
        out_data_o <= in_data_i;
      end
    end else if (pop) begin
      if (level == 2'h2) begin
        out_data_o <= entry1;
        if (push) begin
          entry1 <= in_data_i;
        end
      end else if (push) begin
        out_data_o <= in_data_i;
      end
    end else if (push) begin
      if (level == 2'h0) begin
        out_data_o <= in_data_i;
      end else begin
        entry1 <= in_data_i;
      end
    end
  end
endmodule

// >>> hdl/offset_loader.sv
/*
  Almost-empty and almost-full offset registers with serial loading,
  parallel loading and parallel read-back. Empty offset comes first.
  Assumes the caller holds load controls from logic on the same clock.
*/
`timescale 1ns/1ns
module offset_loader (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_i, // async reset, high
  input wire logic master_reset_n_i, // restores defaults, low
  input wire logic narrow_ports_i, // both ports 9 bits wide
  input wire logic serial_en_i, // shift one serial bit
  input wire logic serial_bit_i, // serial offset bit, lsb first
  input wire logic offset_write_i, // parallel load step
  input wire logic [17:0] offset_data_i, // parallel load data
  input wire logic offset_read_i, // parallel read-back step
  output logic [17:0] offset_rdata_o, // read-back data
  output logic offset_rvalid_o, // read-back data valid, pulse
  output logic [16:0] empty_offset_o, // almost-empty offset
  output logic [16:0] full_offset_o // almost-full offset
);
  logic [4:0] serial_step;
  logic serial_second;
  logic [1:0] load_step;
  logic [1:0] read_step;
  logic [4:0] serial_bits;
  logic [1:0] par_last;
  logic [33:0] both_offsets;

  // step counts differ with the port width
  assign serial_bits = narrow_ports_i ? fifo_rt_pkg::SERIAL_BITS_NARROW
                                      : fifo_rt_pkg::SERIAL_BITS_WIDE;
  assign par_last = narrow_ports_i ? fifo_rt_pkg::PAR_LAST_NARROW : fifo_rt_pkg::PAR_LAST_WIDE;
  assign both_offsets = {full_offset_o, empty_offset_o};

  // picks the slice of one offset a parallel step covers
  function automatic logic [17:0] step_slice(input logic [16:0] value, input logic narrow,
                                             input logic high);
    logic [17:0] result;
    result = 18'h00000;
    if (!narrow) begin
      result = {1'b0, value};
    end else if (high) begin
      result = {10'h000, value[16:9]};
    end else begin
      result = {9'h000, value[8:0]};
    end
    return result;
  endfunction

  // serial and parallel loading; serial x bits per offset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      empty_offset_o <= fifo_rt_pkg::DEFAULT_EMPTY_OFFSET;
      full_offset_o <= fifo_rt_pkg::DEFAULT_FULL_OFFSET;
      serial_step <= 5'h00;
      serial_second <= 1'b0;
      load_step <= 2'h0;
    end else if (!master_reset_n_i) begin
      empty_offset_o <= fifo_rt_pkg::DEFAULT_EMPTY_OFFSET;
      full_offset_o <= fifo_rt_pkg::DEFAULT_FULL_OFFSET;
      serial_step <= 5'h00;
      serial_second <= 1'b0;
      load_step <= 2'h0;
    end else if (serial_en_i) begin
      if (serial_second) begin
        full_offset_o[serial_step] <= serial_bit_i;
      end else begin
        empty_offset_o[serial_step] <= serial_bit_i;
      end
      if (serial_step == serial_bits - 5'h01) begin
        serial_step <= 5'h00;
        serial_second <= !serial_second;
      end else begin
        serial_step <= serial_step + 5'h01;
      end
    end else if (offset_write_i) begin
      // narrow ports take low then high slice of each offset
      if (!narrow_ports_i) begin
        if (load_step[0]) begin
          full_offset_o <= offset_data_i[16:0];
        end else begin
          empty_offset_o <= offset_data_i[16:0];
        end
      end else if (load_step[1]) begin
        if (load_step[0]) begin
          full_offset_o[16:9] <= offset_data_i[7:0];
        end else begin
          full_offset_o[8:0] <= offset_data_i[8:0];
        end
      end else if (load_step[0]) begin
        empty_offset_o[16:9] <= offset_data_i[7:0];
      end else begin
        empty_offset_o[8:0] <= offset_data_i[8:0];
      end
      load_step <= (load_step == par_last) ? 2'h0 : load_step + 2'h1;
    end
  end

  // read-back mirrors the load order
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      read_step <= 2'h0;
      offset_rdata_o <= 18'h00000;
      offset_rvalid_o <= 1'b0;
    end else begin
      offset_rvalid_o <= offset_read_i && master_reset_n_i;
      if (!master_reset_n_i) begin
        read_step <= 2'h0;
      end else if (offset_read_i) begin
        if (narrow_ports_i) begin
          offset_rdata_o <= step_slice(read_step[1] ? both_offsets[33:17] : both_offsets[16:0],
                                       1'b1, read_step[0]);
        end else begin
          offset_rdata_o <= step_slice(read_step[0] ? both_offsets[33:17] : both_offsets[16:0],
                                       1'b0, 1'b0);
        end
        read_step <= (read_step == par_last) ? 2'h0 : read_step + 2'h1;
      end
    end
  end
endmodule

// >>> hdl/fifo_retransmit_and_flags.sv
/*
  Deep FIFO core with retransmit and programmable status flags. Writer and
  reader are logic on the single system clock: a write enable stands for a
  write-clock edge, a read enable for a read-clock edge.
  Assumes master and partial reset come from logic on the same clock and
  that the reader and writer keep the retransmit preconditions.
*/
// Contract
// - standard mode: reader waits for empty indicator high after retransmit
// - passthrough: input room stays low in setup, setup ends valid low
// - passthrough depth is one word more than standard depth
// - style select high at master reset gives normal-latency retransmit
// - style select low at master reset gives zero-latency retransmit
// - zero latency, empty: flag and data appear on the retransmit cycle
// - serial offset load uses 17 or 16 bits per offset by width
// - narrow parallel load and read-back need one extra step per offset
// - synchronous mode: almost-full updates on write-clock edges
// - timing select high at master reset gives synchronous flags
// - timing select low at master reset gives asynchronous flags
// - synchronous almost-full deasserts one cycle after the freeing read
// - synchronous almost-empty deasserts one cycle after the filling write
// - asynchronous almost-full set by write, cleared by read
// - asynchronous almost-empty set by read, cleared by write
// - data outputs driven only while output enable is low
// - synchronous mode: almost-empty updates on read-clock edges
// - almost-empty low at n words or fewer, n plus one in passthrough
// - half-full low beyond half depth, high at half or less
`timescale 1ns/1ns
module fifo_retransmit_and_flags (
  input wire logic clk_sys_i, // system clock, 125 MHz
  input wire logic reset_i, // async reset, high
  input wire logic master_reset_n_i, // clears data and settings, low
  input wire logic partial_reset_n_i, // clears data only, low
  input wire logic retransmit_style_select_i, // high normal, low zero latency
  input wire logic flag_timing_select_i, // high synchronous flags
  input wire logic first_word_passthrough_mode_i, // passthrough timing
  input wire logic narrow_ports_i, // both ports 9 bits wide
  input wire logic write_en_i, // write request
  input wire logic [17:0] write_data_i, // write word
  output logic write_ready_o, // write taken this cycle
  input wire logic read_en_i, // read request
  output logic [17:0] read_data_o, // head word
  output logic read_valid_o, // head word readable
  input wire logic output_enable_n_i, // data drive enable, low
  output logic data_oe_o, // data outputs driven
  input wire logic retransmit_i, // retransmit request, pulse
  output logic retransmit_busy_o, // retransmit setup running
  input wire logic serial_en_i, // serial offset bit strobe
  input wire logic serial_bit_i, // serial offset bit
  input wire logic offset_write_i, // parallel offset load step
  input wire logic [17:0] offset_data_i, // parallel offset data
  input wire logic offset_read_i, // parallel offset read step
  output logic [17:0] offset_rdata_o, // offset read-back data
  output logic offset_rvalid_o, // offset read-back valid
  output logic empty_indicator_n_o, // low while nothing readable
  output logic output_valid_n_o, // low while head word valid
  output logic full_indicator_n_o, // low while full
  output logic input_room_flag_n_o, // low while room
  output logic almost_full_flag_n_o, // low when almost full
  output logic almost_empty_flag_n_o, // low when almost empty
  output logic half_full_flag_n_o // low when beyond half
);
  logic [17:0] mem [fifo_rt_pkg::MEM_DEPTH];
  logic cfg_normal_rt;
  logic cfg_sync_flags;
  logic cfg_passthrough;
  logic cfg_narrow;
  logic [16:0] wr_ptr;
  logic [16:0] rd_ptr;
  logic [17:0] fill;
  logic [17:0] stored;
  logic [17:0] first_word;
  logic [17:0] pend_data;
  logic pend_valid;
  fifo_rt_pkg::rt_state_type rt_state;
  logic [3:0] setup_count;
  logic clear_data;
  logic do_write;
  logic do_read;
  logic rt_zero;
  logic fetch;
  logic buf_in_valid;
  logic [17:0] buf_in_data;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [16:0] empty_offset;
  logic [16:0] full_offset;
  logic [17:0] depth;
  logic [17:0] half_level;
  logic [18:0] empty_level;
  logic full_cond;
  logic almost_full_cond;
  logic almost_empty_cond;
  logic almost_full_sync;
  logic almost_empty_sync;

  // modes caught while master reset is held
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_normal_rt <= fifo_rt_pkg::CFG_NORMAL_RT_RESET;
      cfg_sync_flags <= fifo_rt_pkg::CFG_SYNC_FLAGS_RESET;
      cfg_passthrough <= 1'b0;
      cfg_narrow <= 1'b0;
    end else if (!master_reset_n_i) begin
      cfg_normal_rt <= retransmit_style_select_i;
      cfg_sync_flags <= flag_timing_select_i;
      cfg_passthrough <= first_word_passthrough_mode_i;
      cfg_narrow <= narrow_ports_i;
    end
  end

  // depth and thresholds per mode
  assign depth = cfg_passthrough ? fifo_rt_pkg::DEPTH_PASSTHROUGH
                                 : fifo_rt_pkg::DEPTH_STANDARD;
  assign half_level = cfg_passthrough ? fifo_rt_pkg::HALF_PASSTHROUGH
                                      : fifo_rt_pkg::HALF_STANDARD;
  assign empty_level = {2'h0, empty_offset} + {18'h00000, cfg_passthrough};

  // request qualification; reads wait out the setup
  assign clear_data = !master_reset_n_i || !partial_reset_n_i;
  assign full_cond = (fill >= depth);
  assign do_write = write_en_i && !full_cond && !clear_data;
  assign do_read = read_en_i && buf_out_valid && (rt_state == fifo_rt_pkg::RT_IDLE)
                   && !retransmit_i && !clear_data;
  assign rt_zero = retransmit_i && !cfg_normal_rt && !clear_data;
  assign write_ready_o = do_write;

  // words still in memory, not yet fetched toward the output
  assign stored = {1'b0, wr_ptr} - {1'b0, rd_ptr};
  // fetch only when the pending slot will be free next cycle
  assign fetch = (stored != 18'h00000) && (!pend_valid || buf_in_ready)
                 && !retransmit_i && !clear_data;

  // memory write and read port; no reset on the array keeps it a ram
  always_ff @(posedge clk_sys_i) begin
    if (do_write) begin
      mem[wr_ptr] <= write_data_i;
    end
    if (fetch) begin
      pend_data <= mem[rd_ptr];
    end
  end

  // write pointer and copy of the first word since reset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= 17'h00000;
      first_word <= 18'h00000;
    end else if (clear_data) begin
      wr_ptr <= 17'h00000;
    end else if (do_write) begin
      wr_ptr <= wr_ptr + 17'h00001;
      if (wr_ptr == 17'h00000) begin
        first_word <= write_data_i;
      end
    end
  end

  // read pointer rewinds to the first word
  // no wrap check: the writer stays below depth minus two
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ptr <= 17'h00000;
    end else if (clear_data) begin
      rd_ptr <= 17'h00000;
    end else if (retransmit_i) begin
      // zero latency hands the first word over directly
      rd_ptr <= rt_zero ? 17'h00001 : 17'h00000;
    end else if (fetch) begin
      rd_ptr <= rd_ptr + 17'h00001;
    end
  end

  // pending slot between the ram read and the buffer
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pend_valid <= 1'b0;
    end else if (clear_data || retransmit_i) begin
      pend_valid <= 1'b0;
    end else if (fetch) begin
      pend_valid <= 1'b1;
    end else if (buf_in_ready) begin
      pend_valid <= 1'b0;
    end
  end

  // fill count of words not yet taken by the reader
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fill <= 18'h00000;
    end else if (clear_data) begin
      fill <= 18'h00000;
    end else if (retransmit_i) begin
      // every word since reset is readable again
      fill <= {1'b0, wr_ptr} + {17'h00000, do_write};
    end else if (do_write && !do_read) begin
      fill <= fill + 18'h00001;
    end else if (do_read && !do_write) begin
      fill <= fill - 18'h00001;
    end
  end

  // retransmit setup; the reader keeps the entry conditions
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rt_state <= fifo_rt_pkg::RT_IDLE;
      setup_count <= 4'h0;
    end else if (clear_data) begin
      rt_state <= fifo_rt_pkg::RT_IDLE;
      setup_count <= 4'h0;
    end else begin
      unique case (rt_state)
        fifo_rt_pkg::RT_IDLE: begin
          if (retransmit_i && cfg_normal_rt) begin
            rt_state <= fifo_rt_pkg::RT_SETUP;
            setup_count <= fifo_rt_pkg::RT_SETUP_CYCLES - 4'h1;
          end
        end
        fifo_rt_pkg::RT_SETUP: begin
          if (setup_count == 4'h0) begin
            rt_state <= fifo_rt_pkg::RT_IDLE;
          end else begin
            setup_count <= setup_count - 4'h1;
          end
        end
      endcase
    end
  end
  assign retransmit_busy_o = (rt_state == fifo_rt_pkg::RT_SETUP);

  // buffer input: zero latency pushes the first word at once
  assign buf_in_valid = rt_zero || (pend_valid && !retransmit_i && !clear_data);
  assign buf_in_data = rt_zero ? first_word : pend_data;

  two_entry_buffer out_buffer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .flush_i(retransmit_i || clear_data),
    .in_valid_i(buf_in_valid),
    .in_data_i(buf_in_data),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(read_data_o),
    .out_ready_i(do_read)
  );

  offset_loader offsets (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .master_reset_n_i(master_reset_n_i),
    .narrow_ports_i(cfg_narrow),
    .serial_en_i(serial_en_i),
    .serial_bit_i(serial_bit_i),
    .offset_write_i(offset_write_i),
    .offset_data_i(offset_data_i),
    .offset_read_i(offset_read_i),
    .offset_rdata_o(offset_rdata_o),
    .offset_rvalid_o(offset_rvalid_o),
    .empty_offset_o(empty_offset),
    .full_offset_o(full_offset)
  );

  // data drive follows the output enable only
  assign data_oe_o = !output_enable_n_i;

  // head visibility held off during setup
  assign read_valid_o = buf_out_valid && (rt_state == fifo_rt_pkg::RT_IDLE);
  assign empty_indicator_n_o = read_valid_o;
  assign output_valid_n_o = !read_valid_o;

  // full side; room stays shown through setup since busy masks the full condition
  assign full_indicator_n_o = !full_cond;
  assign input_room_flag_n_o = full_cond && !retransmit_busy_o;

  // almost conditions from the fill
  assign almost_full_cond = ({1'b0, fill} + {2'h0, full_offset}) >= {1'b0, depth};
  assign almost_empty_cond = {1'b0, fill} <= empty_level;

  // synchronous copies lag the fill by one edge
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      almost_full_sync <= 1'b0;
      almost_empty_sync <= 1'b1;
    end else begin
      almost_full_sync <= almost_full_cond;
      almost_empty_sync <= almost_empty_cond;
    end
  end

  // asynchronous mode follows the edge that moved the fill
  // a single clock here means both flag styles differ by exactly one cycle
  assign almost_full_flag_n_o = cfg_sync_flags ? !almost_full_sync : !almost_full_cond;
  assign almost_empty_flag_n_o = cfg_sync_flags ? !almost_empty_sync : !almost_empty_cond;

  // half-full set by the write past half, cleared by the read back to it
  assign half_full_flag_n_o = !(fill > half_level);
endmodule

// >>> verification/fifo_rt_asserts.sv
/* port checker for the retransmit fifo: setup timing, flag pairs, read-back.
   assumes the bind below; sees only the top module's ports. */
`timescale 1ns/1ns
module fifo_rt_asserts (
  input wire logic clk_sys_i, // clock
  input wire logic reset_i, // async reset
  input wire logic master_reset_n_i, // master reset, low
  input wire logic partial_reset_n_i, // partial reset, low
  input wire logic retransmit_style_select_i, // style select
  input wire logic output_enable_n_i, // drive enable, low
  input wire logic data_oe_o, // data driven
  input wire logic retransmit_i, // retransmit pulse
  input wire logic retransmit_busy_o, // setup running
  input wire logic read_valid_o, // head valid
  input wire logic empty_indicator_n_o, // empty, low
  input wire logic output_valid_n_o, // valid, low
  input wire logic full_indicator_n_o, // full, low
  input wire logic input_room_flag_n_o, // room, low
  input wire logic write_en_i, // write request
  input wire logic write_ready_o, // write taken
  input wire logic offset_read_i, // read-back step
  input wire logic offset_rvalid_o // read-back valid
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i || !master_reset_n_i || !partial_reset_n_i);
  logic normal;
  // style copy; master reset is synchronous so it lands one edge later
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) normal <= fifo_rt_pkg::CFG_NORMAL_RT_RESET;
    else if (!master_reset_n_i) normal <= retransmit_style_select_i;
  end
  // setup is four busy cycles, then free
  sequence s_setup;
    retransmit_busy_o [*4] ##1 !retransmit_busy_o;
  endsequence
  property p_normal_rt;
    retransmit_i && normal |=> s_setup;
  endproperty
  property p_zero_rt;
    retransmit_i && !normal |=> read_valid_o && !retransmit_busy_o;
  endproperty
  property p_oe;
    data_oe_o == !output_enable_n_i;
  endproperty
  property p_room_setup;
    retransmit_busy_o |-> !input_room_flag_n_o;
  endproperty
  property p_no_read;
    retransmit_busy_o |-> !read_valid_o && !empty_indicator_n_o;
  endproperty
  property p_flag_pair;
    output_valid_n_o == !read_valid_o && empty_indicator_n_o == read_valid_o;
  endproperty
  property p_write_room;
    write_ready_o |-> write_en_i && full_indicator_n_o;
  endproperty
  property p_rdback;
    offset_read_i |=> offset_rvalid_o;
  endproperty
  a_normal_rt: assert property (p_normal_rt) else $error("normal setup length wrong");
  a_zero_rt: assert property (p_zero_rt) else $error("zero latency data late");
  a_oe: assert property (p_oe) else $error("output drive wrong");
  a_room_setup: assert property (p_room_setup) else $error("room lost in setup");
  a_no_read: assert property (p_no_read) else $error("read open in setup");
  a_flag_pair: assert property (p_flag_pair) else $error("valid flags disagree");
  a_write_room: assert property (p_write_room) else $error("write taken when full");
  a_rdback: assert property (p_rdback) else $error("read-back valid missing");
endmodule
bind fifo_retransmit_and_flags fifo_rt_asserts fifo_rt_asserts_i (.*);

// >>> verification/fifo_user_model.sv
/* writer and reader logic on the far side of the fifo ports.
   assumes the bench adds words through add_i and enables reading. */
`timescale 1ns/1ns
module fifo_user_model (
  input wire logic clk_sys_i, // clock
  input wire logic [7:0] add_i, // words to add
  input wire logic rd_on_i, // reader enabled
  input wire logic write_ready_i, // write taken
  output logic write_en_o = 1'b0, // write request
  output logic [17:0] write_data_o = 18'h00000, // write word
  output logic read_en_o = 1'b0 // reader ready
);
  integer left = 0;
  integer seed = 11;
  // request held until taken; random gaps between words and reads
  always @(posedge clk_sys_i) begin
    if (write_en_o && write_ready_i) begin
      left = left - 1;
      write_data_o <= 18'($random(seed));
    end
    left = left + add_i;
    write_en_o <= (write_en_o && !write_ready_i) || (left > 0 && $random(seed) % 4 != 0);
    read_en_o <= rd_on_i && $random(seed) % 3 != 0;
  end
endmodule

// >>> verification/fifo_retransmit_and_flags_bench.sv
/* self-checking bench: queue model of stored words, flag thresholds, replay.
   assumes the user model and the bound checker. */
`timescale 1ns/1ns
module fifo_retransmit_and_flags_bench;
  logic clk_sys_i = 0, reset_i = 1, master_reset_n_i = 1, partial_reset_n_i = 1;
  logic retransmit_style_select_i = 1, flag_timing_select_i = 1, retransmit_i = 0;
  logic first_word_passthrough_mode_i = 0, output_enable_n_i = 0, rd_on = 0, serial_en_i = 0;
  logic offset_write_i = 0, offset_read_i = 0, data_oe_o, retransmit_busy_o, serial_bit_i = 0;
  logic [17:0] offset_data_i = 18'h00000, write_data_i, read_data_o, offset_rdata_o;
  logic [7:0] add = 8'h00;
  logic write_en_i, read_en_i, write_ready_o, read_valid_o, offset_rvalid_o;
  logic empty_indicator_n_o, output_valid_n_o, full_indicator_n_o, input_room_flag_n_o;
  logic almost_full_flag_n_o, almost_empty_flag_n_o, half_full_flag_n_o;
  logic [17:0] q[$], hist[$];
  logic [1:0] m;
  int errors = 0, comparisons = 0, cycles = 0, thr, seed = 11;
  fifo_retransmit_and_flags fifo_retransmit_and_flags_i (.*, .narrow_ports_i(1'b0));
  fifo_user_model fifo_user_model_i (.clk_sys_i, .add_i(add), .rd_on_i(rd_on),
    .write_ready_i(write_ready_o), .write_en_o(write_en_i), .write_data_o(write_data_i),
    .read_en_o(read_en_i));
  always #4 clk_sys_i = ~clk_sys_i;
  task chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cut a hang short; a run needs under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    output_enable_n_i <= 1'($random(seed));
    if (cycles == 20000) begin
      errors++;
      end_sim;
    end
  end
  // model of stored words; replay restarts at the first word since reset
  always @(posedge clk_sys_i) begin
    if (!master_reset_n_i) begin
      q = {};
      hist = {};
    end
    else if (retransmit_i) q = hist;
    else if (read_en_i && read_valid_o) chk(read_data_o, q.pop_front());
    if (write_en_i && write_ready_o) begin
      q.push_back(write_data_i);
      hist.push_back(write_data_i);
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 0;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      @(posedge clk_sys_i);
      master_reset_n_i <= 0;
      retransmit_style_select_i <= m[1];
      flag_timing_select_i <= m[0];
      first_word_passthrough_mode_i <= m[0] ^ m[1];
      @(posedge clk_sys_i);
      master_reset_n_i <= 1;
      for (int b = 0; b < 32 * m[1]; b++) begin
        serial_en_i <= 1;
        serial_bit_i <= 1'(32'h00050003 >> b);
        @(posedge clk_sys_i);
      end
      serial_en_i <= 0;
      offset_write_i <= !m[1];
      offset_data_i <= 18'h00003;
      @(posedge clk_sys_i);
      offset_data_i <= 18'h00005;
      @(posedge clk_sys_i);
      offset_write_i <= 0;
      offset_read_i <= 1;
      @(posedge clk_sys_i);
      #1 chk(offset_rdata_o, 18'h00003);
      @(posedge clk_sys_i);
      offset_read_i <= 0;
      #1 chk(offset_rdata_o, 18'h00005);
      thr = 3 + int'(m[0] ^ m[1]);
      // one word at a time; sync flags lag the fill by one edge
      for (int k = 1; k <= 6; k++) begin
        @(posedge clk_sys_i);
        add <= 8'h01;
        @(posedge clk_sys_i);
        add <= 8'h00;
        while (hist.size() < k) begin
          @(posedge clk_sys_i);
          #1;
        end
        chk(18'(almost_empty_flag_n_o), 18'(m[0] ? k - 1 > thr : k > thr));
        chk(18'({almost_full_flag_n_o, half_full_flag_n_o}), 18'h00003);
      end
      @(posedge clk_sys_i);
      rd_on <= 1;
      while (q.size() != 0) begin
        @(posedge clk_sys_i);
        #1;
      end
      @(posedge clk_sys_i);
      retransmit_i <= 1; // six written and read, far below depth
      @(posedge clk_sys_i);
      retransmit_i <= 0;
      #1;
      if (m[1]) chk(18'(retransmit_busy_o), 18'h00001);
      else chk(read_data_o, hist[0]);
      chk(18'(read_valid_o), 18'(!m[1]));
      while (q.size() != 0) begin
        @(posedge clk_sys_i);
        #1;
      end
      @(posedge clk_sys_i);
      rd_on <= 0;
    end
    end_sim;
  end
endmodule
